/* File: osw_pkg.sv */
package osw_pkg;
	// Number of switched outputs and bits in one command frame
	localparam int OSW_WIDTH = 8;
	// Command latch after reset: every output off (active-low command)
	localparam logic [7:0] OSW_CMD_RST = 8'hff;
	// Shift register after reset
	localparam logic [7:0] OSW_SHREG_RST = 8'h00;
	// Status word forced after a load_supply over-voltage shutdown
	localparam logic [7:0] OSW_OV_STATUS = 8'hff;
	// Fault latches after reset
	localparam logic [7:0] OSW_FLT_RST = 8'h00;
	// Position of the first bit shifted, output 7
	localparam int OSW_MSB = 7;
	// Synchronised pin bundle: cs_n, sclk, sdi, reset_n, sld, over-voltage, drain, short, thermal
	localparam int OSW_SYNC_W = 6 + 3 * 8;
	// Idle value of the synchroniser bundle: chip select high, reset released
	localparam logic [OSW_SYNC_W-1:0] OSW_SYNC_RST = {1'b1, 2'b00, 1'b1, 26'h0000000};
endpackage

/* File: osw_spi.sv */
`timescale 1ns/1ps
// Contract
// (R1) Chip select low enables transfers and serial_out
// (R2) Chip select rise latches shift register to outputs
// (R3) Chip select fall loads drain status
// (R4) Host keeps serial clock low at chip-select edges
// (R5) Host should idle serial clock low
// (R6) Chip select high: ignore clock, tristate out
// (R7) Sample serial_in on serial clock fall
// (R8) Change serial_out on serial clock rise
// (R9) Host keeps serial_in steady at clock rise
// (R10) Command bit one means output off
// (R11) Eight bits, output 7 first
// (R12) Shift path is FIFO, status MSB first
// (R13) Status one means off, zero means on
// (R14) Serial_out ignores the reset input
// (R15) Reset clears registers, all outputs off
// (R16) Host holds reset low 250 ns minimum
// (R17) Host holds reset until supplies good
// (R18) Host resets after load_supply undervoltage
// (R19) Short latch disabled: shorted output stays limited
// (R20) Short latch enabled: only shorted output off
// (R21) After over-voltage, next status word all ones
// (R22) Extra bits pass through for daisy chains
module osw_spi (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Serial pins from the host
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic reset_n,
	// Serial output pin: level and enable
	output logic sdo,
	output logic sdo_oe,
	// Protection and supply inputs from the analog side
	input wire logic short_latch_disable,
	input wire logic load_supply_ov,
	input wire logic [osw_pkg::OSW_WIDTH-1:0] drain_high,
	input wire logic [osw_pkg::OSW_WIDTH-1:0] short_det,
	input wire logic [osw_pkg::OSW_WIDTH-1:0] thermal_det,
	// Output switch gate drive and current-limit mode
	output logic [osw_pkg::OSW_WIDTH-1:0] gate_on,
	output logic [osw_pkg::OSW_WIDTH-1:0] cur_limit
);
	import osw_pkg::*;

	logic [OSW_SYNC_W-1:0] sync1_q; // First stage, read only by sync2_q
	logic [OSW_SYNC_W-1:0] sync2_q; // Second stage, safe to use
	logic cs_prev_q; // Chip select one cycle older, for edges
	logic sclk_prev_q; // Serial clock one cycle older, for edges
	logic cs_s, sclk_s, sdi_s, rstn_s, sld_s, ov_s;
	logic [7:0] drain_s, short_s, therm_s;
	logic cs_rise, cs_fall, sclk_rise, sclk_fall;
	logic [7:0] shreg_q; // Serial shift register
	logic [7:0] cmd_q; // Output command latch, active low
	logic [7:0] sc_latch_q; // Outputs shut by a short
	logic [7:0] therm_q; // Outputs held off after thermal shutdown
	logic ov_off_q; // All outputs held off after over-voltage
	logic ov_stat_q; // Next status load must read all ones
	logic sdo_q, sdo_oe_q;
	logic [7:0] gate_q, cur_lim_q;
	logic [7:0] status; // Word loaded at chip select fall

	// Two-flop synchroniser for every pin that comes from outside
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1_q <= OSW_SYNC_RST;
			sync2_q <= OSW_SYNC_RST;
		end else begin
			sync1_q <= {cs_n, sclk, sdi, reset_n, short_latch_disable, load_supply_ov,
				drain_high, short_det, thermal_det};
			sync2_q <= sync1_q;
		end
	end

	// Unpack the bundle
	assign {cs_s, sclk_s, sdi_s, rstn_s, sld_s, ov_s, drain_s, short_s, therm_s} = sync2_q;

	// Edge history, taken from the second stage only
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cs_prev_q <= 1'b1;
			sclk_prev_q <= 1'b0;
		end else begin
			cs_prev_q <= cs_s;
			sclk_prev_q <= sclk_s;
		end
	end

	// Edges; serial clock counts only while selected, so idle clocking is harmless
	assign cs_rise = cs_s & ~cs_prev_q;
	assign cs_fall = ~cs_s & cs_prev_q;
	assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_s & ~cs_prev_q; // R6
	assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_s & ~cs_prev_q; // R6

	// Status word: drain high reads one, i.e. off; over-voltage forces all ones
	assign status = ov_stat_q ? OSW_OV_STATUS : drain_s; // R13 R21

	// Shift register: status load on select, sample on serial clock fall
	always_ff @(posedge sys_clk) begin
		if (rst || !rstn_s) begin
			shreg_q <= OSW_SHREG_RST; // R15
		end else if (cs_fall) begin
			shreg_q <= status; // R3
		end else if (sclk_fall) begin
			shreg_q <= {shreg_q[OSW_MSB-1:0], sdi_s}; // R7 R11 R12
		end
	end

	// Serial output level; not touched by the reset pin so chains keep reading
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sdo_q <= 1'b0;
		end else if (cs_fall) begin
			sdo_q <= status[OSW_MSB]; // R12
		end else if (sclk_rise) begin
			sdo_q <= shreg_q[OSW_MSB]; // R8 R22
		end
	end

	// Output driver enabled only while selected
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sdo_oe_q <= 1'b0;
		end else begin
			sdo_oe_q <= ~cs_s; // R1 R6 R14
		end
	end

	// Command latch updated as one word on deselect
	always_ff @(posedge sys_clk) begin
		if (rst || !rstn_s) begin
			cmd_q <= OSW_CMD_RST; // R15
		end else if (cs_rise) begin
			cmd_q <= shreg_q; // R2
		end
	end

	// Short latch-off per output; a new short wins over the clear on reprogramming
	always_ff @(posedge sys_clk) begin
		if (rst || !rstn_s) begin
			sc_latch_q <= OSW_FLT_RST;
		end else begin
			sc_latch_q <= (cs_rise ? OSW_FLT_RST : sc_latch_q) | (short_s & gate_q & {8{~sld_s}}); // R20
		end
	end

	// Thermal hold: output returns only when rewritten after cooling
	always_ff @(posedge sys_clk) begin
		if (rst || !rstn_s) begin
			therm_q <= OSW_FLT_RST;
		end else begin
			therm_q <= (cs_rise ? OSW_FLT_RST : therm_q) | therm_s;
		end
	end

	// Over-voltage: global off until reprogrammed, and flag for the status word
	always_ff @(posedge sys_clk) begin
		if (rst || !rstn_s) begin
			ov_off_q <= 1'b0;
		end else begin
			ov_off_q <= (ov_off_q & ~cs_rise) | ov_s;
		end
	end

	// Status flag cleared at chip select fall, even when the reset pin blocks the load; a fresh event wins
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ov_stat_q <= 1'b0;
		end else begin
			ov_stat_q <= (ov_stat_q & ~cs_fall) | ov_s; // R21
		end
	end

	// Gate drive: command zero turns on unless a protection holds it off
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gate_q <= 8'h00;
		end else begin
			gate_q <= ~cmd_q & ~sc_latch_q & ~therm_q & {8{~ov_off_q}}; // R10
		end
	end

	// Current-limit mode flag: on output shorted while latch-off is disabled
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cur_lim_q <= 8'h00;
		end else begin
			cur_lim_q <= gate_q & short_s & {8{sld_s}}; // R19
		end
	end

	assign sdo = sdo_q;
	assign sdo_oe = sdo_oe_q;
	assign gate_on = gate_q;
	assign cur_limit = cur_lim_q;

	// Driver off one cycle after deselect is seen
	a_sdo_tristate: assert property (@(posedge sys_clk) disable iff (rst) cs_s |=> !sdo_oe_q) // R6
		else $error("serial_out driven while deselected");
	// Driver on while selected, whatever the reset pin does
	a_sdo_enable: assert property (@(posedge sys_clk) disable iff (rst) !cs_s |=> sdo_oe_q) // R1
		else $error("serial_out not enabled while selected");
	// Deselect copies the shift register into the command latch
	a_latch_rise: assert property (@(posedge sys_clk) disable iff (rst)
		cs_rise && rstn_s |=> cmd_q == $past(shreg_q)) // R2
		else $error("command not latched at chip select rise");
	// Select loads status, all ones after over-voltage
	a_status_load: assert property (@(posedge sys_clk) disable iff (rst)
		cs_fall && rstn_s |=> shreg_q == ($past(ov_stat_q) ? OSW_OV_STATUS : $past(drain_s))) // R3
		else $error("status not loaded at chip select fall");
	// Falling serial clock shifts serial_in in at the bottom
	a_sample_fall: assert property (@(posedge sys_clk) disable iff (rst)
		sclk_fall && rstn_s |=> shreg_q == {$past(shreg_q[6:0]), $past(sdi_s)}) // R7
		else $error("serial_in not sampled on falling clock");
	// Rising serial clock presents the top bit
	a_sdo_rise: assert property (@(posedge sys_clk) disable iff (rst)
		sclk_rise |=> sdo_q == $past(shreg_q[OSW_MSB])) // R8
		else $error("serial_out not updated on rising clock");
	// An output commanded off is never driven on
	a_active_low: assert property (@(posedge sys_clk) disable iff (rst)
		1'b1 |=> (gate_q & $past(cmd_q)) == 8'h00) // R10
		else $error("output on while commanded off");
	// Reset pin clears registers and turns everything off two cycles later
	a_reset_clear: assert property (@(posedge sys_clk) disable iff (rst)
		!rstn_s |=> cmd_q == OSW_CMD_RST && shreg_q == OSW_SHREG_RST ##1 gate_q == 8'h00) // R15
		else $error("reset pin did not clear the switch");
	// Latched short shuts the shorted output within two cycles
	a_short_latch: assert property (@(posedge sys_clk) disable iff (rst)
		!sld_s && (short_s & gate_q) != 8'h00 && rstn_s |-> ##2 (gate_q & $past(short_s & gate_q, 2)) == 8'h00) // R20
		else $error("shorted output not shut down");
	// With latch-off disabled, gates move only when a command or a hold moved a cycle earlier
	a_short_limit: assert property (@(posedge sys_clk) disable iff (rst)
		sld_s && rstn_s && $stable(cmd_q) && $stable(sc_latch_q) && $stable(therm_q) && $stable(ov_off_q)
		|=> $stable(gate_q)) // R19
		else $error("output dropped in current-limit mode");
	// Current-limit mode never latches a shorted output off
	a_no_latch_off: assert property (@(posedge sys_clk) disable iff (rst) // R19
		sld_s && rstn_s |=> (sc_latch_q & ~$past(sc_latch_q)) == 8'h00)
		else $error("short latched off while latch-off disabled");
endmodule

/* File: osw_host.sv */
`timescale 1ns/1ps
// Host master model: owns chip select, serial clock and serial data in
module osw_host (
	// Clock used only to align frame starts
	input wire logic sys_clk,
	// Serial pins
	output logic cs_n,
	output logic sclk,
	output logic sdi,
	input wire logic so_pin
);
	// Idle: deselected with the clock parked low
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	// One frame of n bits, MSB first, 800 ns clock period
	task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		@(posedge sys_clk);
		#1;
		// Clock is low at this edge
		cs_n = 1'b0;
		#700;
		for (int i = n - 1; i >= 0; i--) begin
			// Data moves well away from the falling clock edge that samples it
			sdi = tx[i];
			#100;
			sclk = 1'b1;
			#400;
			sclk = 1'b0;
			// Output changed after the rise, read before the next one
			#300;
			rx = {rx[14:0], so_pin};
		end
		#100;
		// Clock still low at the closing edge
		cs_n = 1'b1;
		// Released data line shows the inverse, never a stale level
		sdi = ~sdi;
		#1000;
	endtask
endmodule

/* File: osw_spi_bench.sv */
`timescale 1ns/1ps
// Self-checking bench for the serial control port
module osw_spi_bench;
	import osw_pkg::*;
	// Design pins
	logic sys_clk, rst, cs_n, sclk, sdi, reset_n, sdo, sdo_oe, sld, ov;
	logic [OSW_WIDTH-1:0] drain, short, therm, gate_on, cur_limit;
	// Resolved serial output pin: floats while the driver is off
	wire so_pin;
	logic [15:0] rx;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;
	assign so_pin = sdo_oe ? sdo : 1'bz;
	osw_spi dut (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .reset_n(reset_n),
		.sdo(sdo), .sdo_oe(sdo_oe), .short_latch_disable(sld), .load_supply_ov(ov), .drain_high(drain),
		.short_det(short), .thermal_det(therm), .gate_on(gate_on), .cur_limit(cur_limit));
	osw_host host (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .so_pin(so_pin));
	// 10 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// Compare seen against expected, four-state exact
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task automatic finish_test();
		if (fails == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Inputs move just after the rising edge, so sampling never races
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Hang guard: the whole sequence needs well under 2000 cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end
	// Main sequence
	initial begin
		rst = 1'b1;
		// Device reset pin held low through power-up
		reset_n = 1'b0;
		sld = 1'b0;
		ov = 1'b0;
		drain = 8'hff;
		short = 8'h00;
		therm = 8'h00;
		tick(3);
		rst = 1'b0;
		tick(4);
		// Supplies good: release the device reset with all outputs off
		reset_n = 1'b1;
		tick(4);
		check(gate_on, 8'h00);
		check(sdo_oe, 1'b0);
		// Plain frame: status out while command goes in
		drain = 8'h5a;
		fork
			host.xfer(8, 16'h003c, rx);
			begin
				#600;
				check(sdo_oe, 1'b1);
			end
		join
		check(rx[7:0], 8'h5a);
		check(gate_on, 8'hc3);
		check(sdo_oe, 1'b0);
		// Sixteen bits: first byte passes through to the output pin
		drain = 8'h0f;
		host.xfer(16, 16'ha5f0, rx);
		check(rx, 16'h0fa5);
		check(gate_on, 8'h0f);
		// Over-voltage drops everything; next status word reads all ones
		ov = 1'b1;
		tick(6);
		check(gate_on, 8'h00);
		ov = 1'b0;
		drain = 8'h00;
		host.xfer(8, 16'h0000, rx);
		check(rx[7:0], OSW_OV_STATUS);
		check(gate_on, 8'hff);
		// Current-limit mode keeps a shorted output on
		sld = 1'b1;
		short = 8'h02;
		tick(6);
		check(gate_on, 8'hff);
		check(cur_limit, 8'h02);
		// Latch-off mode drops only the shorted output
		sld = 1'b0;
		short = 8'h01;
		tick(6);
		check(gate_on, 8'hfe);
		check(cur_limit, 8'h00);
		short = 8'h00;
		// Device reset pin forces every output off, held well past its minimum
		reset_n = 1'b0;
		tick(6);
		check(gate_on, 8'h00);
		check(sdo_oe, 1'b0);
		// Frame under reset: driver still follows chip select, command is dropped
		fork
			host.xfer(8, 16'h0000, rx);
			begin
				#600;
				check(sdo_oe, 1'b1);
			end
		join
		check(rx[7:0], OSW_SHREG_RST);
		check(gate_on, 8'h00);
		// Release mid-run, then a normal frame must work again
		reset_n = 1'b1;
		tick(4);
		drain = 8'h3c;
		host.xfer(8, 16'h0081, rx);
		check(rx[7:0], 8'h3c);
		check(gate_on, 8'h7e);
		// Thermal shutdown drops only the hot output
		therm = 8'h02;
		tick(6);
		check(gate_on, 8'h7c);
		finish_test();
	end
endmodule
